// *** core/hswc_ctrl.sv ***
// Halt and clock-stop mode control with wake source selection
`timescale 1ns/1ns
// ==========================================
// Overview of operation
// R1: Halt ends when any one selected wake source becomes true.
// R2: Interrupt, timer carry and port input may be selected together for halt.
// R3: Halt operand with only bit 3 selects wake on accepted interrupt.
// R4: Carry flag, port value kept readable; interrupt wake branches to vector.
// R5: Software tests every selected source after wake, highest priority first.
// R6: Stop instruction stops the oscillator and enters clock-stop mode.
// R7: In clock-stop mode CPU and peripherals get no clock.
// R8: Power failure detector stays inactive throughout clock stop.
// R9: Four-bit stop operand; each one bit enables its wake condition. Here bit 1 (timer carry) never wakes stop: its source is tied to 0.
// R10: After stop wake, wait half the settling time, then resume.
// R11: Interrupt stop wake on enable and request, regardless of global enable.
// R12: Stop ends when any single enabled condition holds. Here an enabled timer carry (bit 1) never holds, so it never ends stop.
// R13: All-zero stop operand wakes only by power-on or CE reset.
// R14: Stop operand bits map like halt: irq, aux, timer carry, port.
module hswc_ctrl #(
  parameter int TICK_CYCLES = hswc_pkg::TICK_CYCLES_DFLT,
  parameter int SETTLE_CYCLES = hswc_pkg::SETTLE_CYCLES_DFLT
) (
  // Clock and reset (power-on or CE reset)
  input wire logic clk,
  input wire logic sys_rst,
  // Instruction decode side
  input wire logic halt_cmd,
  input wire logic stop_cmd,
  input wire logic [3:0] opnd,
  // Interrupt controller side
  input wire logic irq_accept,
  input wire logic source_irq_enable_bit,
  input wire logic source_irq_request_flag,
  input wire logic global_irq_on,
  input wire logic aux_wake_in,
  input wire logic [3:0] wake_port_input,
  // Register port
  input wire hswc_pkg::hswc_bus_t bus,
  output logic [7:0] rdata,
  // Core controls
  output logic cpu_run,
  output logic osc_enable,
  output logic periph_clk_en,
  output logic pfd_enable,
  output logic vector_branch,
  output logic tick_timer_carry_flag
);
  typedef struct packed {
    hswc_pkg::hswc_mode_t mode;
    logic [3:0] sel;
    logic [31:0] settle_cnt;
    logic [7:0] settle_cfg;
    logic carry;
    logic vec;
    logic [3:0] cause;
    logic [7:0] rdata;
  } hswc_state_t;

  hswc_state_t st;
  hswc_state_t next_st;
  logic tick_pulse;
  logic clocks_on;
  hswc_pkg::hswc_src_t halt_src;
  hswc_pkg::hswc_src_t stop_src;
  logic [31:0] settle_half;

  // ==========================================
  // Timer carry divider
  assign clocks_on = (st.mode == hswc_pkg::HSWC_RUN) || (st.mode == hswc_pkg::HSWC_HALT);

  hswc_tick #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_tick (
    .clk(clk),
    .sys_rst(sys_rst),
    .run_en(clocks_on),
    .tick_pulse(tick_pulse)
  );

  function automatic logic wake_hit(input logic [3:0] sel, input hswc_pkg::hswc_src_t src);
    wake_hit = |(sel & src);
  endfunction : wake_hit

  // ==========================================
  // Wake sources
  always_comb begin
    halt_src.irq_request = irq_accept; // [R3]
    halt_src.aux_wake = aux_wake_in;
    halt_src.tick_carry = st.carry;
    halt_src.port_high = |wake_port_input;
    stop_src.irq_request = source_irq_enable_bit && source_irq_request_flag; // [R11]
    stop_src.aux_wake = aux_wake_in; // [R14]
    stop_src.tick_carry = 1'b0; // No clock for the timer while stopped
    stop_src.port_high = |wake_port_input;
  end

  // Half the settling time, at least one cycle
  assign settle_half = (st.settle_cfg == 8'h00) ? 32'(SETTLE_CYCLES / 2) :
    32'((int'(st.settle_cfg) * hswc_pkg::SETTLE_UNIT) / 2); // [R10]

  // ==========================================
  // Mode sequencing
  always_comb begin
    next_st = st;
    next_st.vec = 1'b0;
    next_st.rdata = '0;
    if (tick_pulse) begin
      next_st.carry = 1'b1;
    end
    unique case (st.mode)
      hswc_pkg::HSWC_RUN: begin
        if (stop_cmd) begin
          next_st.mode = hswc_pkg::HSWC_STOP; // [R6]
          next_st.sel = opnd; // [R9]
        end else if (halt_cmd) begin
          next_st.mode = hswc_pkg::HSWC_HALT;
          next_st.sel = opnd; // [R2]
        end
      end
      hswc_pkg::HSWC_HALT: begin
        if (wake_hit(st.sel, halt_src)) begin
          next_st.mode = hswc_pkg::HSWC_RUN; // [R1]
          next_st.cause = st.sel & halt_src; // [R4]
          next_st.vec = st.sel[hswc_pkg::WAKE_BIT_IRQ] && irq_accept; // [R4]
        end
      end
      hswc_pkg::HSWC_STOP: begin
        // Zero operand never hits; only reset leaves
        if (st.sel != hswc_pkg::OPND_NONE && wake_hit(st.sel, stop_src)) begin // [R13]
          next_st.mode = hswc_pkg::HSWC_SETTLE; // [R12]
          next_st.cause = st.sel & stop_src;
          next_st.settle_cnt = (settle_half == 32'h0) ? 32'h1 : settle_half;
        end
      end
      hswc_pkg::HSWC_SETTLE: begin
        if (st.settle_cnt <= 32'h1) begin
          next_st.mode = hswc_pkg::HSWC_RUN; // [R10]
          next_st.settle_cnt = '0;
        end else begin
          next_st.settle_cnt = st.settle_cnt - 32'h1;
        end
      end
      default: begin
        next_st.mode = hswc_pkg::HSWC_RUN;
      end
    endcase
    // Register port: carry cleared by reading status; a new carry wins
    if (bus.wr && bus.addr == hswc_pkg::ADDR_SETTLE) begin
      next_st.settle_cfg = bus.wdata;
    end
    if (bus.rd) begin
      unique case (bus.addr)
        hswc_pkg::ADDR_CTRL: next_st.rdata = {4'h0, st.sel};
        hswc_pkg::ADDR_STATUS: begin
          next_st.rdata = {st.cause, 3'h0, st.carry}; // [R4]
          next_st.carry = tick_pulse;
        end
        hswc_pkg::ADDR_SETTLE: next_st.rdata = st.settle_cfg;
        default: next_st.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st.mode <= hswc_pkg::HSWC_RUN; // [R13]
      st.sel <= hswc_pkg::OPND_NONE;
      st.settle_cnt <= '0;
      st.settle_cfg <= hswc_pkg::SETTLE_RST;
      st.carry <= 1'b0;
      st.vec <= 1'b0;
      st.cause <= hswc_pkg::WAKE_SRC_NONE;
      st.rdata <= '0;
    end else begin
      st <= next_st;
    end
  end

  // ==========================================
  // Outputs
  assign cpu_run = (st.mode == hswc_pkg::HSWC_RUN);
  assign osc_enable = (st.mode != hswc_pkg::HSWC_STOP); // [R6]
  assign periph_clk_en = clocks_on; // [R7]
  assign pfd_enable = (st.mode != hswc_pkg::HSWC_STOP); // [R8]
  assign vector_branch = st.vec;
  assign tick_timer_carry_flag = st.carry;
  assign rdata = st.rdata;
endmodule : hswc_ctrl

// *** core/hswc_pkg.sv ***
// Package: constants, states and carriers for the halt/stop wake control
package hswc_pkg;
  // ==========================================
  // Timing
  localparam int CLK_MHZ = 250;
  localparam int TICK_MS = 100;
  localparam int TICK_CYCLES_DFLT = TICK_MS * 1000 * CLK_MHZ;
  localparam int SETTLE_CYCLES_DFLT = 8192;
  // ==========================================
  // Operand bits, shared by halt and stop
  localparam int WAKE_BIT_IRQ = 3;
  localparam int WAKE_BIT_AUX = 2;
  localparam int WAKE_BIT_TICK = 1;
  localparam int WAKE_BIT_PORT = 0;
  localparam logic [3:0] OPND_NONE = 4'h0;
  localparam logic [3:0] WAKE_SRC_NONE = 4'h0;
  // ==========================================
  // Register port
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h1;
  localparam logic [3:0] ADDR_SETTLE = 4'h2;
  localparam logic [7:0] SETTLE_RST = 8'h40;
  localparam int SETTLE_UNIT = 64;

  typedef enum logic [3:0] {
    HSWC_RUN = 4'b0001,
    HSWC_HALT = 4'b0010,
    HSWC_STOP = 4'b0100,
    HSWC_SETTLE = 4'b1000
  } hswc_mode_t;

  typedef struct packed {
    logic irq_request;
    logic aux_wake;
    logic tick_carry;
    logic port_high;
  } hswc_src_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } hswc_bus_t;
endpackage : hswc_pkg

// *** core/hswc_tick.sv ***
// Divider that makes the periodic timer carry enable pulse
`timescale 1ns/1ns
module hswc_tick #(
  parameter int TICK_CYCLES = hswc_pkg::TICK_CYCLES_DFLT
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Control
  input wire logic run_en,
  output logic tick_pulse
);
  typedef struct packed {
    logic [31:0] cnt;
    logic pulse;
  } hswc_tick_state_t;

  hswc_tick_state_t st;
  hswc_tick_state_t next_st;

  always_comb begin
    next_st = st;
    next_st.pulse = 1'b0;
    if (!run_en) begin
      next_st.cnt = '0;
    end else if (st.cnt == 32'(TICK_CYCLES - 1)) begin
      next_st.cnt = '0;
      next_st.pulse = 1'b1;
    end else begin
      next_st.cnt = st.cnt + 32'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign tick_pulse = st.pulse;
endmodule : hswc_tick

// *** test/hswc_ctrl_asserts.sv ***
// Port assertions for the halt/stop wake control
`timescale 1ns/1ns
module hswc_ctrl_asserts (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Commands and wake sources
  input wire logic halt_cmd,
  input wire logic stop_cmd,
  input wire logic [3:0] opnd,
  input wire logic irq_accept,
  input wire logic source_irq_enable_bit,
  input wire logic source_irq_request_flag,
  input wire logic aux_wake_in,
  input wire logic [3:0] wake_port_input,
  // Register port and core controls
  input wire hswc_pkg::hswc_bus_t bus,
  input wire logic [7:0] rdata,
  input wire logic cpu_run,
  input wire logic osc_enable,
  input wire logic periph_clk_en,
  input wire logic pfd_enable,
  input wire logic vector_branch
);
  logic [3:0] sel;
  logic in_halt;
  logic stop_wake;
  assign in_halt = !cpu_run && periph_clk_en;
  assign stop_wake = (sel[0] && |wake_port_input) || (sel[2] && aux_wake_in)
    || (sel[3] && source_irq_enable_bit && source_irq_request_flag);
  // Operand only counts when taken in run mode
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sel <= 4'h0;
    end else if (cpu_run && (halt_cmd || stop_cmd)) begin
      sel <= opnd;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence s_settle;
    (osc_enable && !cpu_run) [*8];
  endsequence
  sequence s_vector;
    cpu_run && vector_branch ##1 !vector_branch;
  endsequence
  a_stop_osc_off: assert property (cpu_run && stop_cmd |=> !osc_enable) else $error("osc runs");
  a_stop_all_dead: assert property (!osc_enable |-> !cpu_run && !periph_clk_en) else $error("clock live");
  a_stop_pfd_off: assert property (!osc_enable |-> !pfd_enable) else $error("pfd on");
  a_halt_irq_wake: assert property (in_halt && sel[3] && irq_accept |=> s_vector) else $error("no vector");
  a_halt_port_wake: assert property (in_halt && sel[0] && |wake_port_input |=> cpu_run) else $error("halt");
  a_stop_any_wake: assert property (!osc_enable && stop_wake |=> osc_enable && !cpu_run) else $error("stop");
  a_stop_hold_on: assert property (!osc_enable && !stop_wake |=> !osc_enable) else $error("woke");
  a_settle_wait: assert property ($rose(osc_enable) && !$past(sys_rst) |-> s_settle) else $error("short");
  a_rdata_idle: assert property (!$past(bus.rd) |-> rdata == 8'h00) else $error("rdata");
endmodule : hswc_ctrl_asserts

// *** test/tb_hswc_ctrl.sv ***
// Self-checking bench for the halt/stop wake control
`timescale 1ns/1ns
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin bad_count++; $display("[ERR] %s %h %h", nm, e, g); end end
module tb_hswc_ctrl;
  logic clk = 1'b0, sys_rst = 1'b1, halt_cmd = 1'b0, stop_cmd = 1'b0, irq_accept = 1'b0;
  logic source_irq_enable_bit = 1'b0, source_irq_request_flag = 1'b0, global_irq_on = 1'b0, aux_wake_in = 1'b0;
  logic [3:0] opnd = 4'h0, wake_port_input = 4'h0;
  hswc_pkg::hswc_bus_t bus = '0;
  logic [7:0] rdata;
  logic cpu_run, osc_enable, periph_clk_en, pfd_enable, vector_branch, tick_timer_carry_flag;
  int bad_count = 0, n_compared = 0;
  logic [3:0] m_tab [4] = '{4'h1, 4'h4, 4'h8, 4'h8};
  hswc_ctrl #(.TICK_CYCLES(20), .SETTLE_CYCLES(64)) u_hswc_ctrl (.clk, .sys_rst, .halt_cmd, .stop_cmd, .opnd,
    .irq_accept, .source_irq_enable_bit, .source_irq_request_flag, .global_irq_on, .aux_wake_in,
    .wake_port_input, .bus, .rdata, .cpu_run, .osc_enable, .periph_clk_en, .pfd_enable, .vector_branch,
    .tick_timer_carry_flag);
  initial forever #2 clk = ~clk;
  task automatic close_out();
    if (bad_count == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : close_out
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask : wr
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [7:0] q);
    @(posedge clk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus.rd <= 1'b0;
    #1;
    q = rdata;
  endtask : rd
  task automatic cmd(input logic h, input logic s, input logic [3:0] o);
    @(posedge clk);
    halt_cmd <= h;
    stop_cmd <= s;
    opnd <= o;
    @(posedge clk);
    halt_cmd <= 1'b0;
    stop_cmd <= 1'b0;
    #1;
  endtask : cmd
  task automatic src(input logic [3:0] s, input logic e);
    @(posedge clk);
    source_irq_request_flag <= s[3];
    source_irq_enable_bit <= e;
    aux_wake_in <= s[2];
    wake_port_input <= {s[0], 3'h0};
  endtask : src
  task automatic wait_run(output int n);
    n = 0;
    while (cpu_run !== 1'b1 && n < 200) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n >= 200) begin
      bad_count++;
      close_out();
    end
  endtask : wait_run
  initial begin
    #400000;
    bad_count++;
    close_out();
  end
  // ==========================================
  // Main sequence
  initial begin
    logic [7:0] q;
    int n;
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    rd(hswc_pkg::ADDR_SETTLE, q);
    `CHK("settle", hswc_pkg::SETTLE_RST, q)
    wr(hswc_pkg::ADDR_SETTLE, 8'h01);
    rd(4'hf, q);
    `CHK("unmapped", 8'h00, q)
    cmd(1'b1, 1'b0, 4'h8);
    `CHK("halt", 2'b01, {cpu_run, periph_clk_en})
    src(4'h5, 1'b1);
    repeat (3) @(posedge clk);
    irq_accept <= 1'b1;
    #1;
    `CHK("halt_hold", 1'b0, cpu_run)
    @(posedge clk);
    irq_accept <= 1'b0;
    #1;
    `CHK("irq_wake", 2'b11, {cpu_run, vector_branch})
    src(4'h0, 1'b0);
    cmd(1'b1, 1'b0, 4'hb);
    src(4'h1, 1'b0);
    @(posedge clk);
    #1;
    `CHK("port_wake", 2'b10, {cpu_run, vector_branch})
    src(4'h0, 1'b0);
    rd(hswc_pkg::ADDR_STATUS, q);
    `CHK("cause", 4'h1, q[7:4])
    cmd(1'b1, 1'b0, 4'h2);
    wait_run(n);
    rd(hswc_pkg::ADDR_STATUS, q);
    `CHK("carry", 2'b10, {q[0], tick_timer_carry_flag})
    rd(hswc_pkg::ADDR_CTRL, q);
    `CHK("ctrl", 8'h02, q)
    for (int k = 0; k < 4; k++) begin
      @(posedge clk);
      global_irq_on <= k[0];
      cmd(1'b0, 1'b1, m_tab[k]);
      `CHK("stop", 3'b000, {osc_enable, pfd_enable, periph_clk_en})
      // Request without enable must not wake
      src(~m_tab[k] | 4'h8, 1'b0);
      repeat (3) @(posedge clk);
      #1;
      `CHK("stop_hold", 1'b0, osc_enable)
      src(m_tab[k], 1'b1);
      @(posedge clk);
      #1;
      `CHK("stop_wake", 2'b10, {osc_enable, cpu_run})
      src(4'h0, 1'b0);
      wait_run(n);
      `CHK("settle_len", 1'b1, n > 28 && n < 36)
    end
    cmd(1'b0, 1'b1, 4'h0);
    src(4'hf, 1'b1);
    repeat (4) @(posedge clk);
    sys_rst <= 1'b1;
    #1;
    `CHK("zero_hold", 1'b0, osc_enable)
    @(posedge clk);
    sys_rst <= 1'b0;
    #1;
    `CHK("reset_exit", 2'b11, {osc_enable, cpu_run})
    rd(hswc_pkg::ADDR_SETTLE, q);
    `CHK("settle_rst", hswc_pkg::SETTLE_RST, q)
    close_out();
  end
endmodule : tb_hswc_ctrl
bind hswc_ctrl hswc_ctrl_asserts u_hswc_ctrl_asserts (.clk, .sys_rst, .halt_cmd, .stop_cmd, .opnd, .irq_accept,
  .source_irq_enable_bit, .source_irq_request_flag, .aux_wake_in, .wake_port_input, .bus, .rdata, .cpu_run,
  .osc_enable, .periph_clk_en, .pfd_enable, .vector_branch);
